// ---- rtl/serial_port.sv ----
// Function
// [RL1] transmit and receive each have their own sixteen-character FIFO.
// [RL2] characters carry 5, 6, 7, 8 or 9 data bits in both directions.
// [RL3] parity is even, odd, space, mark, address marking or absent.
// [RL4] each character has a start bit and one or two stop bits.
// [RL5] a break can be sent on request and a received break is flagged.
// [RL6] receive overrun and missing stop bits are detected and reported.
// [RL7] modem handshake lines are driven and sampled for flow control.
// [RL8] the write-only transmit holding location queues one byte per write.
// [RL9] short characters are right aligned with zero upper bits.
// [RL10] reading the receive buffer returns the oldest receive FIFO entry.
// [RL11] with FIFOs disabled the receive path holds a single character.
// [RL12] receive buffer, transmit holding and divisor low share one address.
// [RL13] the interrupt enable register shares its address with divisor high.
// [RL14] a divisor access bit switches the shared addresses to the divisor.
// [RL15] bits go least significant first, idle high, start low, divided rate.
// [RL16] the receiver samples mid-bit on a 16x tick and checks start midway.
`timescale 1ns/1ps
`include "serial_port_consts.svh"
module serial_port
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // serial line and modem lines
  input wire logic rx_i,
  output logic tx_o,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic dcd_i,
  input wire logic ri_i,
  output logic rts_o,
  output logic dtr_o,
  // interrupt
  output logic irq_o
);
  //////////////////////////////////////////////////////////////////////////
  // registers and bus decode
  logic ack_q;
  logic [31:0] dat_q;
  logic [15:0] div_q;
  logic [9:0] lctl_q;
  logic [3:0] fctl_q, mctl_q, ier_q, istat_q, mstat_q;
  logic req, wr, rd, dlab;
  logic [31:0] rdata;
  assign req = cyc_i && stb_i && !ack_q;
  assign wr = req && we_i && sel_i[0];
  assign rd = req && !we_i;
  assign dlab = lctl_q[`LC_DLAB];
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // fifo wires
  logic tf_valid, tf_pop, rf_valid, rf_pop, rf_push, rf_ready, tx_idle;
  logic [7:0] tf_data;
  logic [11:0] rf_data, rx_entry;
  logic [4:0] rf_count;
  logic rx_full;
  logic [3:0] nbits;
  parity_e pmode;
  assign pmode = parity_e'(lctl_q[`LC_PAR_LSB +: 3]);
  assign nbits = (lctl_q[2:0] > 3'h4) ? 4'h9 : {1'b0, lctl_q[2:0]} + 4'h5; // RL2

  // one-entry receive buffer when fifos are off
  assign rx_full = fctl_q[`FC_EN] ? !rf_ready : (rf_count != 5'h00); // RL11

  // transmit fifo
  char_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_tx_fifo ( // RL1
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(wr && adr_i == `ADR_FCTL && dat_i[`FC_TXCLR]),
    .wr_valid_i(wr && adr_i == `ADR_DATA && !dlab), // RL8 RL12
    .wr_ready_o(),
    .wr_data_i(dat_i[7:0]),
    .rd_valid_o(tf_valid),
    .rd_ready_i(tf_pop),
    .rd_data_o(tf_data),
    .count_o()
  );

  // receive fifo: {break, frame err, parity err, bit 8, data}
  char_fifo #(.WIDTH(12), .DEPTH(`FIFO_DEPTH)) u_rx_fifo ( // RL1
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(wr && adr_i == `ADR_FCTL && dat_i[`FC_RXCLR]),
    .wr_valid_i(rf_push && !rx_full),
    .wr_ready_o(rf_ready),
    .wr_data_i(rx_entry),
    .rd_valid_o(rf_valid),
    .rd_ready_i(rf_pop),
    .rd_data_o(rf_data),
    .count_o(rf_count)
  );
  assign rf_pop = rd && adr_i == `ADR_DATA && !dlab; // RL10

  // read mux
  always_comb begin
    rdata = 32'h0000_0000;
    case (adr_i)
      `ADR_DATA: rdata[7:0] = dlab ? div_q[7:0] : rf_data[7:0]; // RL12 RL14
      `ADR_IER: rdata[7:0] = dlab ? div_q[15:8] : {4'h0, ier_q}; // RL13
      `ADR_LCTL: rdata[9:0] = lctl_q;
      `ADR_FCTL: rdata[3:0] = fctl_q & 4'h9;
      `ADR_MCTL: rdata[3:0] = mctl_q;
      `ADR_LSTAT: rdata[7:0] = {rf_data[8] && rf_valid, tx_idle, !tf_valid,
                                rf_data[11:9] & {3{rf_valid}}, 1'b0,
                                rf_valid};
      `ADR_ISTAT: rdata[3:0] = istat_q;
      `ADR_MSTAT: rdata[3:0] = {ri_i, dcd_i, dsr_i, cts_i};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // bus answer: one wait state, data from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (rd) dat_q <= rdata;
    end
  end

  // writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= `DIV_RST;
      lctl_q <= `LCTL_RST;
      fctl_q <= `FCTL_RST;
      mctl_q <= 4'h0;
      ier_q <= 4'h0;
    end else if (wr) begin
      case (adr_i)
        `ADR_DATA: if (dlab) div_q[7:0] <= dat_i[7:0]; // RL14
        `ADR_IER: begin
          if (dlab) div_q[15:8] <= dat_i[7:0]; // RL13 RL14
          else ier_q <= dat_i[3:0];
        end
        `ADR_LCTL: lctl_q <= dat_i[9:0];
        `ADR_FCTL: fctl_q <= dat_i[3:0] & 4'h9;
        `ADR_MCTL: mctl_q <= dat_i[3:0];
        default: ;
      endcase
    end
  end

  // modem outputs
  assign dtr_o = mctl_q[`MC_DTR]; // RL7
  assign rts_o = mctl_q[`MC_RTS] && !rx_full; // RL7

  //////////////////////////////////////////////////////////////////////////
  // 16x oversampling tick from the divisor
  logic [15:0] bcnt_q;
  logic tick;
  assign tick = (bcnt_q <= 16'h0001);
  always_ff @(posedge clk_i) begin
    if (rst_i) bcnt_q <= `DIV_RST;
    else bcnt_q <= tick ? div_q : bcnt_q - 16'h0001; // RL15 RL16
  end

  // parity of the configured bits
  function automatic logic par_bit(input parity_e m, input logic [8:0] d,
                                   input logic [3:0] n, input logic a);
    logic x;
    x = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) x = x ^ d[i];
    end
    case (m)
      PAR_EVEN: par_bit = x;
      PAR_ODD: par_bit = !x;
      PAR_MARK: par_bit = 1'b1;
      PAR_ADDR: par_bit = a;
      default: par_bit = 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // transmitter
  line_state_e ts_q;
  logic [3:0] ttk_q, tbit_q;
  logic [8:0] tsh_q;
  logic tpar_q, tline_q, tstop_q;
  logic tx_go;
  assign tx_idle = (ts_q == ST_IDLE);
  assign tx_go = tx_idle && tf_valid && !lctl_q[`LC_BREAK] &&
                 (!fctl_q[`FC_AUTOCTS] || cts_i); // RL7
  assign tf_pop = tx_go;
  assign tx_o = tline_q && !lctl_q[`LC_BREAK]; // RL5

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts_q <= ST_IDLE;
      ttk_q <= 4'h0;
      tbit_q <= 4'h0;
      tsh_q <= 9'h000;
      tpar_q <= 1'b0;
      tline_q <= 1'b1;
      tstop_q <= 1'b0;
    end else begin
      case (ts_q)
        ST_IDLE: begin
          tline_q <= 1'b1; // RL15
          if (tx_go) begin
            tsh_q <= {lctl_q[`LC_TXADDR], tf_data};
            tpar_q <= par_bit(pmode, {lctl_q[`LC_TXADDR], tf_data}, nbits,
                              lctl_q[`LC_TXADDR]); // RL3
            ts_q <= ST_START;
            ttk_q <= 4'h0;
            tline_q <= 1'b0; // RL4
          end
        end
        ST_START, ST_DATA, ST_PAR, ST_STOP: begin
          if (tick) begin
            ttk_q <= ttk_q + 4'h1;
            if (ttk_q == `OVS_LAST) begin
              case (ts_q)
                ST_START: begin
                  ts_q <= ST_DATA;
                  tbit_q <= 4'h1;
                  tline_q <= tsh_q[0]; // RL15
                  tsh_q <= tsh_q >> 1;
                end
                ST_DATA: begin
                  if (tbit_q == nbits) begin
                    ts_q <= (pmode == PAR_NONE) ? ST_STOP : ST_PAR;
                    tline_q <= (pmode == PAR_NONE) ? 1'b1 : tpar_q;
                    tstop_q <= 1'b0;
                  end else begin
                    tbit_q <= tbit_q + 4'h1;
                    tline_q <= tsh_q[0];
                    tsh_q <= tsh_q >> 1;
                  end
                end
                ST_PAR: begin
                  ts_q <= ST_STOP;
                  tline_q <= 1'b1;
                end
                default: begin
                  if (lctl_q[`LC_STOP2] && !tstop_q) tstop_q <= 1'b1; // RL4
                  else ts_q <= ST_IDLE;
                end
              endcase
            end
          end
        end
        default: ts_q <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receiver
  line_state_e rs_q;
  logic [3:0] rtk_q, rbit_q;
  logic [8:0] rsh_q, rdat;
  logic rpar_q, rone_q, rpush_q;
  logic [11:0] rent_q;
  assign rf_push = rpush_q;
  assign rx_entry = rent_q;

  // right align the shifted bits
  always_comb begin
    rdat = rsh_q >> (4'h9 - nbits); // RL9
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs_q <= ST_IDLE;
      rtk_q <= 4'h0;
      rbit_q <= 4'h0;
      rsh_q <= 9'h000;
      rpar_q <= 1'b0;
      rone_q <= 1'b0;
      rpush_q <= 1'b0;
      rent_q <= 12'h000;
    end else begin
      rpush_q <= 1'b0;
      case (rs_q)
        ST_IDLE: begin
          rtk_q <= 4'h0;
          if (!rx_i) rs_q <= ST_START;
        end
        ST_START, ST_DATA, ST_PAR, ST_STOP: begin
          if (tick) begin
            rtk_q <= rtk_q + 4'h1;
            case (rs_q)
              ST_START: begin
                if (rtk_q == `OVS_MID) begin
                  rtk_q <= 4'h0;
                  rs_q <= rx_i ? ST_IDLE : ST_DATA; // RL16
                  rbit_q <= 4'h0;
                  rone_q <= 1'b0;
                end
              end
              ST_DATA: begin
                if (rtk_q == `OVS_LAST) begin
                  rsh_q <= {rx_i, rsh_q[8:1]}; // RL15 RL16
                  rone_q <= rone_q | rx_i;
                  rbit_q <= rbit_q + 4'h1;
                  if (rbit_q + 4'h1 == nbits) begin
                    rs_q <= (pmode == PAR_NONE) ? ST_STOP : ST_PAR;
                  end
                end
              end
              ST_PAR: begin
                if (rtk_q == `OVS_LAST) begin
                  rpar_q <= rx_i;
                  rone_q <= rone_q | rx_i;
                  rs_q <= ST_STOP;
                end
              end
              default: begin
                if (rtk_q == `OVS_LAST) begin
                  rent_q[7:0] <= rdat[7:0];
                  rent_q[8] <= (pmode == PAR_ADDR) ? rpar_q : rdat[8];
                  rent_q[9] <= (pmode != PAR_NONE) && (pmode != PAR_ADDR) &&
                    (rpar_q != par_bit(pmode, rdat, nbits, 1'b0)); // RL3
                  rent_q[10] <= !rx_i; // RL6
                  rent_q[11] <= !rx_i && !rone_q; // RL5
                  rpush_q <= 1'b1;
                  rs_q <= ST_IDLE;
                end
              end
            endcase
          end
        end
        default: rs_q <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status: sticky, write one to clear, set wins
  logic [3:0] ev, clr;
  logic tf_empty_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mstat_q <= 4'h0;
      tf_empty_q <= 1'b1;
    end else begin
      mstat_q <= {ri_i, dcd_i, dsr_i, cts_i}; // RL7
      tf_empty_q <= !tf_valid;
    end
  end
  assign ev[`IS_RX] = rf_push && !rx_full;
  assign ev[`IS_TXE] = !tf_valid && !tf_empty_q;
  assign ev[`IS_LINE] = rf_push && (rx_full || (|rent_q[11:9])); // RL6
  assign ev[`IS_MODEM] = (mstat_q != {ri_i, dcd_i, dsr_i, cts_i}); // RL7
  assign clr = (wr && adr_i == `ADR_ISTAT) ? dat_i[3:0] : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) istat_q <= 4'h0;
    else istat_q <= (istat_q & ~clr) | ev;
  end
  assign irq_o = |(istat_q & ier_q);
endmodule // serial_port

// ---- common/serial_port_consts.svh ----
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
// register byte addresses
`define ADR_DATA 12'h00c0
`define ADR_IER 12'h00c4
`define ADR_PORT1 12'h00d0
`define ADR_LCTL 12'h0100
`define ADR_FCTL 12'h0104
`define ADR_MCTL 12'h0108
`define ADR_LSTAT 12'h010c
`define ADR_ISTAT 12'h0110
`define ADR_MSTAT 12'h0114
// line control fields
`define LC_LEN_LSB 0
`define LC_PAR_LSB 3
`define LC_STOP2 6
`define LC_BREAK 7
`define LC_DLAB 8
`define LC_TXADDR 9
// fifo control fields
`define FC_EN 0
`define FC_RXCLR 1
`define FC_TXCLR 2
`define FC_AUTOCTS 3
// modem control fields
`define MC_DTR 0
`define MC_RTS 1
// interrupt status / enable fields
`define IS_RX 0
`define IS_TXE 1
`define IS_LINE 2
`define IS_MODEM 3
// reset values
`define LCTL_RST 10'h0003
`define DIV_RST 16'h0001
`define FCTL_RST 4'h1
// timing: last tick of a bit (16 ticks per bit), start check tick
`define OVS_LAST 4'hf
`define OVS_MID 4'h7
`define FIFO_DEPTH 16
`endif

// ---- common/serial_port_pkg.sv ----
package serial_port_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_PAR = 3'h2,
    ST_STOP = 3'h6
  } line_state_e;
  typedef enum logic [2:0] {
    PAR_NONE = 3'h0,
    PAR_EVEN = 3'h1,
    PAR_ODD = 3'h2,
    PAR_SPACE = 3'h3,
    PAR_MARK = 3'h4,
    PAR_ADDR = 3'h5
  } parity_e;
endpackage

// ---- rtl/char_fifo.sv ----
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  // fill side
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  // drain side
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q, rptr_q;
  logic [AW:0] cnt_q;
  logic do_wr, do_rd;

  // handshakes
  assign wr_ready_o = (cnt_q != FULL) && !clr_i;
  assign rd_valid_o = (cnt_q != '0) && !clr_i;
  assign do_wr = wr_valid_i && wr_ready_o;
  assign do_rd = rd_valid_o && rd_ready_i;
  assign rd_data_o = mem_q[rptr_q];
  assign count_o = cnt_q;

  // storage
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_q[wptr_q] <= wr_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) wptr_q <= wptr_q + 1'b1;
      if (do_rd) rptr_q <= rptr_q + 1'b1;
      if (do_wr && !do_rd) cnt_q <= cnt_q + 1'b1;
      else if (do_rd && !do_wr) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // char_fifo

// ---- sim/serial_port_checker.sv ----
`timescale 1ns/1ps
module serial_port_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus side
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // line and interrupt side
  input wire logic tx_o,
  input wire logic rts_o,
  input wire logic dtr_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // bus answer timing and read data holding
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in the next cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("answer held longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
    else $error("answer without a request");
  a_read_hold: assert property ($changed(dat_o) |-> ack_o && !$past(we_i))
    else $error("read data moved outside a read");
  // values right after reset
  a_tx_idle: assert property ($fell(rst_i) |-> tx_o)
    else $error("line not idle high after reset");
  a_irq_quiet: assert property ($fell(rst_i) |-> !irq_o)
    else $error("interrupt raised after reset");
  a_modem_off: assert property ($fell(rst_i) |-> !dtr_o && !rts_o)
    else $error("handshake outputs active after reset");
  // a start bit lasts at least nine clocks
  a_start_len: assert property ($fell(tx_o) |=> !tx_o [*8])
    else $error("start bit too short");
  c_write: cover property (ack_o && $past(we_i));
  c_irq: cover property ($rose(irq_o));
  c_start: cover property ($fell(tx_o));
endmodule // serial_port_checker
bind serial_port serial_port_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
  .tx_o(tx_o), .rts_o(rts_o), .dtr_o(dtr_o), .irq_o(irq_o));

// ---- sim/serial_peer.sv ----
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT = 16
) (
  // clock
  input wire logic clk_i,
  // serial lines
  input wire logic line_i,
  output logic line_o,
  // modem lines and captured characters
  output logic [3:0] mdm_o,
  output logic [7:0] got_o,
  output int got_cnt_o
);
  logic [7:0] cap;
  initial begin
    line_o = 1'b1;
    mdm_o = 4'h0;
    got_o = 8'h00;
    got_cnt_o = 0;
  end
  // handshake levels toward the port
  task automatic set_modem(input logic [3:0] v);
    mdm_o <= v;
  endtask
  // one frame of eight bits, stop level set by the caller, low to force frame errors
  task automatic send(input logic [7:0] b, input logic stop);
    line_o <= 1'b0;
    repeat (BIT) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (BIT) @(posedge clk_i);
    end
    line_o <= stop;
    repeat (BIT) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (BIT) @(posedge clk_i);
  endtask
  // sample each transmitted data bit at its middle
  always begin
    @(negedge line_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      cap[i] = line_i;
    end
    repeat (BIT) @(posedge clk_i);
    got_o = cap;
    got_cnt_o++;
  end
endmodule // serial_peer

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`include "serial_port_consts.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack_o, tx_o, rx_line, rts_o, dtr_o, irq_o;
  logic [3:0] mdm;
  logic [7:0] got;
  int got_cnt;
  int comparisons = 0;
  int miscompares = 0;
  int cycles = 0;
  serial_port uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_i(rx_line),
    .tx_o(tx_o), .cts_i(mdm[0]), .dsr_i(mdm[1]), .dcd_i(mdm[2]),
    .ri_i(mdm[3]), .rts_o(rts_o), .dtr_o(dtr_o), .irq_o(irq_o));
  serial_peer #(.BIT(16)) peer (.clk_i(clk_i), .line_i(tx_o),
    .line_o(rx_line), .mdm_o(mdm), .got_o(got), .got_cnt_o(got_cnt));
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdchk(input string name, input logic [11:0] a,
                       input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(name, rd, exp);
  endtask
  task automatic wait_got(input int k, input logic [7:0] exp);
    while (got_cnt < k) @(posedge clk_i);
    chk("tx_byte", got, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rdchk("line_stat", `ADR_LSTAT, 32'h0000_0060);
    rdchk("line_ctl", `ADR_LCTL, 32'h0000_0003);
    rdchk("fifo_ctl", `ADR_FCTL, 32'h0000_0001);
    rdchk("unmapped", `ADR_PORT1, 32'h0000_0000);
    $display("reset values done");
  endtask
  task automatic t_div;
    wr(`ADR_IER, 32'h0000_0005);
    wr(`ADR_LCTL, 32'h0000_0103);
    wr(`ADR_DATA, 32'h0000_0002);
    rdchk("div_low", `ADR_DATA, 32'h0000_0002);
    rdchk("div_high", `ADR_IER, 32'h0000_0000);
    wr(`ADR_DATA, 32'h0000_0001);
    wr(`ADR_LCTL, 32'h0000_0003);
    rdchk("irq_enable", `ADR_IER, 32'h0000_0005);
    rdchk("no_queue", `ADR_LSTAT, 32'h0000_0060);
    wr(`ADR_IER, 32'h0000_0000);
    $display("divisor sharing done");
  endtask
  task automatic t_tx;
    wr(`ADR_DATA, 32'h0000_00a5);
    wr(`ADR_DATA, 32'h0000_003c);
    wait_got(1, 8'ha5);
    wait_got(2, 8'h3c);
    $display("transmit done");
  endtask
  task automatic t_modem;
    wr(`ADR_MCTL, 32'h0000_0003);
    peer.set_modem(4'h5);
    repeat (2) @(posedge clk_i);
    chk("dtr", dtr_o, 1'b1);
    chk("rts", rts_o, 1'b1);
    rdchk("modem_stat", `ADR_MSTAT, 32'h0000_0005);
    $display("modem lines done");
  endtask
  task automatic t_rx;
    peer.send(8'h5a, 1'b1);
    rdchk("rx_byte", `ADR_DATA, 32'h0000_005a);
    wr(`ADR_LCTL, 32'h0000_0000);
    peer.send(8'hf3, 1'b1);
    rdchk("rx_short", `ADR_DATA, 32'h0000_0013);
    wr(`ADR_LCTL, 32'h0000_0003);
    $display("receive done");
  endtask
  task automatic t_err;
    wr(`ADR_ISTAT, 32'h0000_000f);
    peer.send(8'h00, 1'b0);
    rdchk("err_stat", `ADR_LSTAT, 32'h0000_0079);
    chk("irq_masked", irq_o, 1'b0);
    wr(`ADR_IER, 32'h0000_0004);
    chk("irq_on", irq_o, 1'b1);
    wr(`ADR_ISTAT, 32'h0000_0004);
    chk("irq_clear", irq_o, 1'b0);
    rdchk("err_byte", `ADR_DATA, 32'h0000_0000);
    wr(`ADR_ISTAT, 32'h0000_000f);
    $display("line errors done");
  endtask
  task automatic t_fifo;
    for (int i = 0; i < 17; i++) peer.send(8'h10 + i[7:0], 1'b1);
    chk("rts_full", rts_o, 1'b0);
    rdchk("overrun", `ADR_ISTAT, 32'h0000_0005);
    for (int i = 0; i < 16; i++) rdchk("fifo_order", `ADR_DATA, i + 16);
    rdchk("drained", `ADR_LSTAT, 32'h0000_0060);
    $display("fifo depth done");
  endtask
  task automatic t_single;
    wr(`ADR_FCTL, 32'h0000_0000);
    peer.send(8'h61, 1'b1);
    peer.send(8'h62, 1'b1);
    rdchk("single_hold", `ADR_DATA, 32'h0000_0061);
    rdchk("single_empty", `ADR_LSTAT, 32'h0000_0060);
    wr(`ADR_FCTL, 32'h0000_0001);
    $display("single buffer done");
  endtask
  // even parity, parity slot driven low: parity error, no frame error
  task automatic t_parity;
    wr(`ADR_LCTL, 32'h0000_000b);
    peer.send(8'h01, 1'b0);
    rdchk("par_stat", `ADR_LSTAT, 32'h0000_0065);
    rdchk("par_byte", `ADR_DATA, 32'h0000_0001);
    wr(`ADR_LCTL, 32'h0000_0003);
    wr(`ADR_ISTAT, 32'h0000_000f);
    $display("parity done");
  endtask
  task automatic t_break;
    wr(`ADR_LCTL, 32'h0000_0083);
    chk("break_line", tx_o, 1'b0);
    repeat (16) @(posedge clk_i);
    wr(`ADR_LCTL, 32'h0000_0003);
    chk("break_end", tx_o, 1'b1);
    $display("break done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_div();
    t_tx();
    t_modem();
    t_rx();
    t_err();
    t_fifo();
    t_single();
    t_parity();
    t_break();
    summarize();
  end
endmodule // tb_top
